// >>> rtl/spi_acc_slave.sv
// SPI slave giving register and FIFO access to an external master.
`timescale 1ns/1ps
module spi_acc_slave
  import spi_acc_pkg::*;
#(
  parameter logic [spi_acc_pkg::ADDR_W-1:0] FIFO_ADDR =
    spi_acc_pkg::FIFO_ADDR_DEF
) (
  // Clock, reset, enable
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_ce,
  // SPI pins
  input  wire logic                          i_sck,
  input  wire logic                          i_nss_n,
  input  wire logic                          i_mosi,
  output logic                               o_miso,
  output logic                               o_miso_oe,
  // Register and FIFO access port
  output logic                               o_wr_stb,
  output spi_acc_pkg::wr_req_s               o_wr,
  output logic                               o_rd_stb,
  output logic [spi_acc_pkg::ADDR_W-1:0]     o_rd_addr,
  input  wire logic [spi_acc_pkg::DATA_W-1:0] i_rd_data,
  // Status
  output logic                               o_busy
);
  import spi_acc_pkg::*;

  // The framing needs one flag bit above the address, and a bit counter
  // that wraps exactly once per byte.
  if (ADDR_W + 1 != DATA_W || (1 << CNT_W) != DATA_W
      || WNR_BIT != DATA_W - 1 || MSB_BIT != DATA_W - 1) begin : g_chk
    $error("Package field widths do not fit the byte framing");
  end

  // ---------------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------------
  logic [PIN_N-1:0] pin_lvl;
  logic [PIN_N-1:0] pin_rise;
  logic [PIN_N-1:0] pin_fall;

  spi_pin_sync #(
    .W       (PIN_N)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce),
    // Select enters inverted, so the synchroniser's reset level reads as
    // deselected and no false frame follows a reset.
    .i_async ({i_mosi, ~i_nss_n, i_sck}),
    .o_level (pin_lvl),
    .o_rise  (pin_rise),
    .o_fall  (pin_fall)
  );

  logic sel;
  logic sck_rise;
  logic sck_fall;
  logic mosi_s;

  always_comb begin
    sel      = pin_lvl[PIN_NSS];
    sck_rise = pin_rise[PIN_SCK];
    sck_fall = pin_fall[PIN_SCK];
    mosi_s   = pin_lvl[PIN_MOSI];
  end

  // ---------------------------------------------------------------------
  // Frame state
  // ---------------------------------------------------------------------
  frame_st_e         state_q,   state_d;
  logic [CNT_W-1:0]  bit_cnt_q, bit_cnt_d;
  logic [DATA_W-1:0] rx_q,      rx_d;
  logic [DATA_W-1:0] tx_q,      tx_d;
  logic [DATA_W-1:0] rdata_q,   rdata_d;
  logic [ADDR_W-1:0] addr_q,    addr_d;
  logic              wr_mode_q, wr_mode_d;
  logic              rcap_q,    rcap_d;
  logic              miso_q,    miso_d;
  logic              oe_q,      oe_d;
  logic              wr_stb_q,  wr_stb_d;
  logic              rd_stb_q,  rd_stb_d;
  logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
  wr_req_s           wr_q,      wr_d;

  logic [DATA_W-1:0] nb;
  logic [DATA_W-1:0] ld_byte;
  logic [ADDR_W-1:0] nxt_addr;
  logic              byte_done;
  logic              in_addr;
  logic              load;

  function automatic logic is_fifo(input logic [ADDR_W-1:0] a);
    return a == FIFO_ADDR;
  endfunction

  always_comb begin
    state_d   = state_q;
    bit_cnt_d = bit_cnt_q;
    rx_d      = rx_q;
    tx_d      = tx_q;
    rdata_d   = rdata_q;
    addr_d    = addr_q;
    wr_mode_d = wr_mode_q;
    miso_d    = miso_q;
    rd_addr_d = rd_addr_q;
    wr_d      = wr_q;
    wr_stb_d  = 1'b0;
    rd_stb_d  = 1'b0;
    rcap_d    = rd_stb_q;
    oe_d      = sel;
    nb        = {rx_q[DATA_W-2:0], mosi_s};
    in_addr   = (state_q != ST_DATA);
    byte_done = sel && sck_rise && (bit_cnt_q == BIT_LAST);
    nxt_addr  = is_fifo(addr_q) ? addr_q
                                : ADDR_W'(addr_q + ADDR_ONE);
    // Read data is taken straight from the port when it arrives in the
    // same cycle as the load, which buys one cycle of margin at high SCK.
    ld_byte   = rcap_q ? i_rd_data : rdata_q;
    load      = sel && sck_fall && (state_q == ST_DATA)
                && (bit_cnt_q == BIT_FIRST);
    if (rcap_q) begin
      rdata_d = i_rd_data;
    end
    if (!sel) begin
      // A partial byte is simply dropped; nothing was committed yet.
      state_d   = ST_IDLE;
      bit_cnt_d = BIT_FIRST;
      rx_d      = BYTE_ZERO;
      tx_d      = BYTE_ZERO;
    end else begin
      if (state_q == ST_IDLE) begin
        state_d = ST_ADDR;
      end
      if (sck_rise) begin
        rx_d      = nb;
        bit_cnt_d = CNT_W'(bit_cnt_q + 1'b1);
      end
      if (byte_done && in_addr) begin
        wr_mode_d = nb[WNR_BIT];
        addr_d    = nb[ADDR_W-1:0];
        state_d   = ST_DATA;
        rdata_d   = BYTE_ZERO;
        // Old contents are fetched for writes too, except at the FIFO,
        // where a fetch would pop an entry the master never asked for.
        if (!(nb[WNR_BIT] && is_fifo(nb[ADDR_W-1:0]))) begin
          rd_stb_d  = 1'b1;
          rd_addr_d = nb[ADDR_W-1:0];
        end
      end else if (byte_done) begin
        addr_d = nxt_addr;
        if (wr_mode_q) begin
          wr_stb_d  = 1'b1;
          wr_d.addr = addr_q;
          wr_d.data = nb;
        end
        rdata_d = BYTE_ZERO;
        if (!(wr_mode_q && is_fifo(addr_q))) begin
          rd_stb_d  = 1'b1;
          rd_addr_d = nxt_addr;
        end
      end
      if (sck_fall) begin
        if (load) begin
          miso_d = ld_byte[MSB_BIT];
          tx_d   = {ld_byte[DATA_W-2:0], 1'b0};
        end else begin
          miso_d = tx_q[MSB_BIT];
          tx_d   = {tx_q[DATA_W-2:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= BIT_FIRST;
      rx_q      <= BYTE_ZERO;
      tx_q      <= BYTE_ZERO;
      rdata_q   <= BYTE_ZERO;
      addr_q    <= '0;
      wr_mode_q <= 1'b0;
      rcap_q    <= 1'b0;
      miso_q    <= 1'b0;
      oe_q      <= 1'b0;
      wr_stb_q  <= 1'b0;
      rd_stb_q  <= 1'b0;
      rd_addr_q <= '0;
      wr_q      <= '0;
    end else if (i_ce) begin
      state_q   <= state_d;
      bit_cnt_q <= bit_cnt_d;
      rx_q      <= rx_d;
      tx_q      <= tx_d;
      rdata_q   <= rdata_d;
      addr_q    <= addr_d;
      wr_mode_q <= wr_mode_d;
      rcap_q    <= rcap_d;
      miso_q    <= miso_d;
      oe_q      <= oe_d;
      wr_stb_q  <= wr_stb_d;
      rd_stb_q  <= rd_stb_d;
      rd_addr_q <= rd_addr_d;
      wr_q      <= wr_d;
    end
  end

  always_comb begin
    o_miso    = miso_q;
    o_miso_oe = oe_q;
    o_wr_stb  = wr_stb_q;
    o_wr      = wr_q;
    o_rd_stb  = rd_stb_q;
    o_rd_addr = rd_addr_q;
    o_busy    = (state_q != ST_IDLE);
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst || !i_ce);

  oe_released_a: assert property (!sel |=> !o_miso_oe)
    else $error("MISO driven while deselected");
  oe_driven_a: assert property (sel |=> o_miso_oe)
    else $error("MISO not driven while selected");
  miso_on_fall_a: assert property ($changed(o_miso) |-> $past(sck_fall))
    else $error("MISO changed away from SCK falling edge");
  capture_rise_a: assert property (sel && sck_rise |=> rx_q[0] == $past(mosi_s))
    else $error("MOSI bit not captured on rising edge");
  addr_decode_a: assert property (byte_done && in_addr |=>
    state_q == ST_DATA && wr_mode_q == $past(rx_q[DATA_W-2])
    && addr_q == $past(nb[ADDR_W-1:0]))
    else $error("Address byte decoded wrongly");
  msb_first_a: assert property (load |=> o_miso == $past(ld_byte[MSB_BIT]))
    else $error("Data byte not sent MSB first");
  fifo_hold_a: assert property (byte_done && !in_addr && is_fifo(addr_q)
    |=> addr_q == $past(addr_q))
    else $error("FIFO address moved within frame");
  burst_inc_a: assert property (byte_done && !in_addr && !is_fifo(addr_q)
    |=> addr_q == ADDR_W'($past(addr_q) + ADDR_ONE))
    else $error("Burst address did not increment");
  frame_end_a: assert property (!sel |=> state_q == ST_IDLE
    && bit_cnt_q == BIT_FIRST && !o_wr_stb)
    else $error("Frame state not cleared on deselect");
  busy_frame_a: assert property (sel |=> o_busy)
    else $error("Busy not raised while selected");
  old_value_a: assert property (byte_done && !in_addr && wr_mode_q
    && !is_fifo(addr_q) |=> o_wr_stb && o_rd_stb
    && o_rd_addr == ADDR_W'(o_wr.addr + ADDR_ONE))
    else $error("Old value of next register not fetched");
  abort_drop_a: assert property (!sel && bit_cnt_q != BIT_FIRST
    |=> bit_cnt_q == BIT_FIRST ##1 !o_wr_stb)
    else $error("Partial byte not discarded");

  burst_write_c: cover property (o_wr_stb && !is_fifo(o_wr.addr)
    ##[1:200] o_wr_stb);
  fifo_read_c: cover property (o_rd_stb && is_fifo(o_rd_addr) && !wr_mode_q
    ##[1:200] o_rd_stb);
  abort_c: cover property (state_q == ST_DATA && bit_cnt_q != BIT_FIRST
    ##1 !sel);

endmodule

// >>> common/spi_acc_pkg.sv
// Constants and carrier types for the SPI register and FIFO access slave.
package spi_acc_pkg;

  // ---------------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W   = 7;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned CNT_W    = 3;
  localparam int unsigned WNR_BIT  = 7;
  localparam int unsigned MSB_BIT  = 7;
  localparam logic [CNT_W-1:0]  BIT_FIRST = 3'h0;
  localparam logic [CNT_W-1:0]  BIT_LAST  = 3'h7;
  localparam logic [ADDR_W-1:0] ADDR_ONE  = 7'h01;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  // Default location of the data FIFO in the address space.
  localparam logic [ADDR_W-1:0] FIFO_ADDR_DEF = 7'h00;

  // ---------------------------------------------------------------------
  // Pin synchroniser indices
  // ---------------------------------------------------------------------
  localparam int unsigned PIN_N    = 3;
  localparam int unsigned PIN_SCK  = 0;
  localparam int unsigned PIN_NSS  = 1;
  localparam int unsigned PIN_MOSI = 2;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10
  } frame_st_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wr_req_s;

endpackage

// >>> rtl/spi_pin_sync.sv
// Two-stage synchroniser with edge detection for the SPI pins.
`timescale 1ns/1ps
module spi_pin_sync #(
  parameter int unsigned W = 3
) (
  // Clock, reset, enable
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  // Asynchronous pins
  input  wire logic [W-1:0] i_async,
  // Synchronised levels and edges
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  // The first stage feeds only the second; edges come from later stages.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else if (i_ce) begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  always_comb begin
    o_level = sync_q;
    o_rise  = sync_q & ~prev_q;
    o_fall  = ~sync_q & prev_q;
  end

endmodule

// >>> sim/spi_host_model.sv
// Behavioural SPI master standing in for the host microcontroller.
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input  wire logic i_clk,
  // SPI pins
  input  wire logic i_miso,
  output logic      o_sck,
  output logic      o_nss_n,
  output logic      o_mosi
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic [7:0] sh;

  initial begin
    o_sck   = 1'b0;
    o_nss_n = 1'b1;
    o_mosi  = 1'b0;
    sh      = 8'h00;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Sends nbits from tx_q, MSB first; a count short of whole bytes aborts.
  task automatic frame(input int nbits);
    logic [7:0] b;
    b = 8'h00;
    o_nss_n <= 1'b0;
    wait_clk(4);
    for (int i = 0; i < nbits; i++) begin
      if (i % 8 == 0) b = tx_q.pop_front();
      o_mosi <= b[7 - i % 8];
      wait_clk(4);
      o_sck <= 1'b1;
      wait_clk(4);
      // MISO is taken late in the high phase, since the slave's answer
      // lags the pin edge by its synchroniser.
      sh = {sh[6:0], i_miso};
      if (i % 8 == 7) rx_q.push_back(sh);
      o_sck <= 1'b0;
    end
    wait_clk(4);
    // The clock stands still and MOSI is no longer meaningful.
    o_nss_n <= 1'b1;
    o_mosi  <= ~o_mosi;
    wait_clk(8);
  endtask
endmodule

// >>> sim/spi_register_fifo_access_slave_bench.sv
// Self-checking bench for the SPI register and FIFO access slave.
`timescale 1ns/1ps
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); \
  end \
end
module spi_register_fifo_access_slave_bench;
  import spi_acc_pkg::*;
  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [2:0] n;
  } row_s;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       sck, nss_n, mosi, miso, miso_oe, wr_stb, rd_stb, busy;
  wire        miso_w;
  wr_req_s    wr;
  logic [6:0] rd_addr;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] regs[128];
  logic [7:0] shadow[128];
  logic [7:0] fifo_q[$];
  logic [7:0] exp_fifo[$];
  wr_req_s    wr_log[$];
  int         n_mismatch = 0;
  int         compares = 0;
  row_s       rows[6] = '{'{1'b0, 7'h10, 3'h1}, '{1'b1, 7'h10, 3'h3},
                          '{1'b0, 7'h0F, 3'h4}, '{1'b1, 7'h00, 3'h3},
                          '{1'b0, 7'h00, 3'h3}, '{1'b0, 7'h7D, 3'h2}};

  always #10 clk = ~clk;
  assign miso_w = miso_oe ? miso : 1'bz;

  spi_acc_slave i_spi_acc_slave (
    .i_clk(clk), .i_rst(rst), .i_ce(1'b1),
    .i_sck(sck), .i_nss_n(nss_n), .i_mosi(mosi),
    .o_miso(miso), .o_miso_oe(miso_oe),
    .o_wr_stb(wr_stb), .o_wr(wr), .o_rd_stb(rd_stb),
    .o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_busy(busy)
  );

  spi_host_model i_spi_host_model (
    .i_clk(clk), .i_miso(miso_w), .o_sck(sck), .o_nss_n(nss_n),
    .o_mosi(mosi)
  );

  // ---------------------------------------------------------------
  // Register file and FIFO behind the access port
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (rd_stb) begin
      if (rd_addr != FIFO_ADDR_DEF) rd_data <= regs[rd_addr];
      else if (fifo_q.size() > 0) rd_data <= fifo_q.pop_front();
      else rd_data <= 8'h00;
    end else begin
      // A stale answer keeps moving so a late sample cannot pass.
      rd_data <= ~rd_data;
    end
    if (wr_stb) begin
      wr_log.push_back(wr);
      if (wr.addr == FIFO_ADDR_DEF) fifo_q.push_back(wr.data);
      else regs[wr.addr] <= wr.data;
    end
  end

  // ---------------------------------------------------------------
  // Frame runner and verdict
  // ---------------------------------------------------------------
  task automatic run_row(input row_s r);
    logic       fifo;
    logic [6:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] g;
    wr_req_s    gw;
    i_spi_host_model.tx_q.push_back({r.wr, r.addr});
    for (int k = 0; k < r.n; k++)
      i_spi_host_model.tx_q.push_back(8'hA0 + 8'(k) + {1'b0, r.addr});
    i_spi_host_model.frame(8 * (int'(r.n) + 1));
    void'(i_spi_host_model.rx_q.pop_front());
    `CHK(wr_log.size(), r.wr ? int'(r.n) : 0)
    for (int k = 0; k < r.n; k++) begin
      fifo = (r.addr == FIFO_ADDR_DEF);
      a = fifo ? r.addr : r.addr + 7'(k);
      d = 8'hA0 + 8'(k) + {1'b0, r.addr};
      if (!fifo) e = shadow[a];
      else if (r.wr || exp_fifo.size() == 0) e = 8'h00;
      else e = exp_fifo.pop_front();
      g = i_spi_host_model.rx_q.pop_front();
      `CHK(g, e)
      if (r.wr) begin
        gw = wr_log.pop_front();
        `CHK(gw, {a, d})
        if (fifo) exp_fifo.push_back(d);
        else shadow[a] = d;
      end
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end

  initial begin
    for (int i = 0; i < 128; i++) begin
      regs[i] = 8'(i * 5) ^ 8'h3C;
      shadow[i] = regs[i];
    end
    repeat (12) @(posedge clk);
    `CHK({miso_oe, wr_stb, rd_stb, busy, wr, rd_addr}, 26'h0)
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({miso_oe, busy}, 2'h0)
    repeat (8) @(posedge clk);
    `CHK(miso_w, 1'bz)
    foreach (rows[i]) run_row(rows[i]);
    // Select rises in mid data byte, then in mid address byte.
    i_spi_host_model.tx_q.push_back({1'b1, 7'h20});
    i_spi_host_model.tx_q.push_back(8'h5C);
    i_spi_host_model.frame(13);
    i_spi_host_model.tx_q.push_back({1'b1, 7'h30});
    i_spi_host_model.frame(4);
    i_spi_host_model.rx_q.delete();
    `CHK(wr_log.size(), 0)
    run_row('{1'b0, 7'h20, 3'h1});
    run_row('{1'b1, 7'h30, 3'h2});
    // A reset in mid-run must clear the held access port outputs.
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK({miso_oe, wr_stb, rd_stb, busy, wr, rd_addr}, 26'h0)
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({miso_oe, busy}, 2'h0)
    repeat (4) @(posedge clk);
    run_row('{1'b0, 7'h31, 3'h1});
    `CHK(miso_w, 1'bz)
    `CHK(busy, 1'b0)
    finish_test();
  end
endmodule
